// >>> verilog/rds_cfg_regs.svh
// Settings word layout, reset values and timing constants of the decoder control block
`ifndef RDS_CFG_REGS_SVH
`define RDS_CFG_REGS_SVH

// ----------------------------------------
// Settings word, first bit shifted in is bit 0
// ----------------------------------------
`define CFG_WORD_BITS 14
`define CFG_LIMIT_LSB 0
`define CFG_DECISION_LSB 3
`define CFG_THRESH_LSB 5
`define CFG_XTAL_BIT 7
`define CFG_PLOCK_BIT 8
`define CFG_PSEL_BIT 9
`define CFG_STD_BIT 10
`define CFG_PINMODE_LSB 11

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CFG_RESET_WORD 14'h1A12
`define LIMIT_RESET 3'h2
`define DECISION_RESET 2'h2
`define PINMODE_RESET 3'h3

// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define ERR_UNCORRECTABLE 3'h6
`define LIMIT_MAX_LEGAL 3'h5
`define ERR_SET_BLOCKS 6'h30
`define ERR_BIN1_MAX 6'h14
`define ERR_BIN2_MAX 6'h28
`define THRESH_1 5'h01
`define THRESH_4 5'h04
`define THRESH_8 5'h08
`define THRESH_12 5'h0C

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYS_CLK_MHZ 125
`define SYNC_PULSE_NS 421000

`endif

// >>> verilog/rds_cfg_pkg.sv
// Types shared by the decoder control block
`default_nettype none

package rds_cfg_pkg;

	// ----------------------------------------
	// Modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		DEC_HARD = 2'h0,
		DEC_SOFT_A = 2'h1,
		DEC_SOFT_B = 2'h2,
		DEC_ILLEGAL = 2'h3
	} decision_t;

	typedef enum logic [2:0] {
		PH_AUTO_IDLE = 3'h1,
		PH_AUTO_RUN = 3'h2,
		PH_LOCKED = 3'h4
	} phase_state_t;

	// ----------------------------------------
	// Settings, packed as shifted in (bit 0 first)
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] pin_mode;
		logic standard_select;
		logic phase_select;
		logic phase_lock;
		logic crystal_select;
		logic [1:0] request_threshold;
		logic [1:0] decision_mode;
		logic [2:0] corr_limit;
	} settings_t;

	// ----------------------------------------
	// One open-drain pin: drive low while oe_n is low
	// ----------------------------------------
	typedef struct packed {
		logic out;
		logic oe_n;
	} od_pin_t;

endpackage

`default_nettype wire

// >>> verilog/bit_sync.sv
// Two flip-flop synchroniser for a single level
`timescale 1ns/10ps
`default_nettype none

module bit_sync
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level
	input wire logic async_in,
	output logic sync_out
);

	logic stage1_reg;

	// First stage is read only by the second
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stage1_reg <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end

endmodule
`default_nettype wire

// >>> verilog/cfg_shift_rx.sv
// Serial settings receiver on the control bus clock
`timescale 1ns/10ps
`default_nettype none
`include "rds_cfg_regs.svh"

module cfg_shift_rx
	import rds_cfg_pkg::*;
#(
	parameter int WORD_BITS = `CFG_WORD_BITS
)
(
	// Bus clock domain
	input wire logic bus_clk,
	input wire logic bus_rst,
	// Serial pins
	input wire logic bus_ce,
	input wire logic bus_data,
	// Completed word, stable between frames
	output logic [WORD_BITS-1:0] word_reg,
	output logic done_toggle_reg
);

	logic [WORD_BITS-1:0] shift_reg;
	logic [4:0] count_reg;
	wire last_bit = (count_reg == 5'(WORD_BITS - 1));
	wire [WORD_BITS-1:0] shift_next = {bus_data, shift_reg[WORD_BITS-1:1]};

	// ----------------------------------------
	// Bit counter, cleared by the frame signal itself
	// ----------------------------------------
	// The bus clock may stop outside frames, so the frame end clears the count
	always_ff @(posedge bus_clk or negedge bus_ce)
	begin
		if (!bus_ce)
			count_reg <= 5'h00;
		else if (!last_bit)
			count_reg <= count_reg + 5'h01;
	end

	// ----------------------------------------
	// Shift and latch
	// ----------------------------------------
	always_ff @(posedge bus_clk)
	begin
		if (bus_rst)
		begin
			shift_reg <= '0;
			word_reg <= WORD_BITS'(`CFG_RESET_WORD);
			done_toggle_reg <= 1'b0;
		end
		else if (bus_ce)
		begin
			shift_reg <= shift_next;
			if (last_bit)
			begin
				word_reg <= shift_next;
				done_toggle_reg <= ~done_toggle_reg;
			end
		end
	end

endmodule
`default_nettype wire

// >>> verilog/rds_cfg_outputs.sv
// Decoder settings, block error grading, read request and status pin drive
//
// Behaviour
// - Correction limit field caps corrected bits
// - Two-bit field picks hard or soft
// - Reset: limit two bits, soft B
// - Soft modes work even with zero limit
// - Soft A corrects less readily than B
// - Over-limit blocks report the uncorrectable code
// - Read request low at buffered threshold
// - Read request pulls its open-drain line low
// - Crystal select bit, reset to low rate
// - Unlocked phase tracks ARI, restarts at select
// - Locked phase: select 0 is 90, 1 is 0
// - Standard select enables offset word E
// - Pin mode field, reset to mode 3
// - Pin mode bit 2 flips status polarity
// - Mode 1 pins show traffic flags
// - Mode 4 grades errored blocks per 48
// - Sync pin level, mode 3 block pulse
// - Sync pin shows previous block state
`timescale 1ns/10ps
`default_nettype none
`include "rds_cfg_regs.svh"

module rds_cfg_outputs
	import rds_cfg_pkg::*;
#(
	parameter int SYNC_PULSE_CYCLES = `SYNC_PULSE_NS * `SYS_CLK_MHZ / 1000,
	parameter int BUF_COUNT_BITS = 5
)
(
	// System clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Serial control bus, own clock domain
	input wire logic bus_clk,
	input wire logic bus_rst,
	input wire logic bus_ce,
	input wire logic bus_data,
	// Decoder core events
	input wire logic block_start,
	input wire logic block_done,
	input wire logic [2:0] block_err_bits,
	input wire logic sync_reset,
	// Decoder core levels
	input wire logic synced,
	input wire logic tp_flag,
	input wire logic ta_flag,
	input wire logic ari_detected,
	input wire logic rds_detected,
	input wire logic [BUF_COUNT_BITS-1:0] buffered_blocks,
	// Settings to the core
	output logic [2:0] corr_limit_reg,
	output decision_t decision_reg,
	output logic soft_enable_reg,
	output logic soft_strong_reg,
	output logic crystal_select_reg,
	output logic offset_e_enable_reg,
	output logic phase_zero_reg,
	// Graded block result
	output logic [2:0] err_info_reg,
	output logic err_info_valid_reg,
	// Open-drain pins
	output od_pin_t read_request_reg,
	output od_pin_t status_pin_a_reg,
	output od_pin_t status_pin_b_reg,
	output od_pin_t sync_pin_reg,
	output od_pin_t rds_present_pin_reg
);

	// ----------------------------------------
	// Settings crossing from the bus domain
	// ----------------------------------------
	logic [`CFG_WORD_BITS-1:0] bus_word;
	logic bus_toggle;
	logic toggle_sync;
	logic toggle_seen_reg;
	settings_t cfg_reg;

	cfg_shift_rx #(
		.WORD_BITS(`CFG_WORD_BITS)
	) u_rx (
		.bus_clk(bus_clk),
		.bus_rst(bus_rst),
		.bus_ce(bus_ce),
		.bus_data(bus_data),
		.word_reg(bus_word),
		.done_toggle_reg(bus_toggle)
	);

	bit_sync u_toggle_sync (
		.clk(sys_clk),
		.rst(rst),
		.async_in(bus_toggle),
		.sync_out(toggle_sync)
	);

	// Word is held stable from its toggle until the next frame ends
	wire word_arrived = toggle_sync ^ toggle_seen_reg;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			toggle_seen_reg <= 1'b0;
			cfg_reg <= settings_t'(`CFG_RESET_WORD);
		end
		else
		begin
			toggle_seen_reg <= toggle_sync;
			if (word_arrived)
				cfg_reg <= settings_t'(bus_word);
		end
	end

	// ----------------------------------------
	// Decoding of settings
	// ----------------------------------------
	// Illegal limit patterns fall back to detection only
	wire limit_legal = (cfg_reg.corr_limit <= `LIMIT_MAX_LEGAL);
	wire [2:0] limit_next = limit_legal ? cfg_reg.corr_limit : 3'h0;
	// Illegal decision value falls back to hard decision
	wire decision_t decision_next = (cfg_reg.decision_mode == DEC_ILLEGAL) ? DEC_HARD
		: decision_t'(cfg_reg.decision_mode);
	wire soft_next = (decision_next != DEC_HARD);
	wire strong_next = (decision_next == DEC_SOFT_B);
	wire [2:0] pin_mode = cfg_reg.pin_mode;
	wire [1:0] mode_low = pin_mode[1:0];
	wire active_high = pin_mode[2];

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			corr_limit_reg <= `LIMIT_RESET;
			decision_reg <= decision_t'(`DECISION_RESET);
			soft_enable_reg <= 1'b1;
			soft_strong_reg <= 1'b1;
			crystal_select_reg <= 1'b0;
			offset_e_enable_reg <= 1'b0;
		end
		else
		begin
			corr_limit_reg <= limit_next;
			decision_reg <= decision_next;
			soft_enable_reg <= soft_next;
			soft_strong_reg <= strong_next;
			crystal_select_reg <= cfg_reg.crystal_select;
			offset_e_enable_reg <= cfg_reg.standard_select;
		end
	end

	// ----------------------------------------
	// Block grading
	// ----------------------------------------
	// Soft decision with a zero limit still passes error-free blocks only
	wire over_limit = (block_err_bits > corr_limit_reg);
	wire [2:0] info_next = over_limit ? `ERR_UNCORRECTABLE : block_err_bits;
	logic uncorrectable_reg;
	logic error_free_reg;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			err_info_reg <= 3'h0;
			err_info_valid_reg <= 1'b0;
			uncorrectable_reg <= 1'b0;
			error_free_reg <= 1'b1;
		end
		else
		begin
			err_info_valid_reg <= block_done;
			if (block_done)
			begin
				err_info_reg <= info_next;
				uncorrectable_reg <= over_limit;
				error_free_reg <= (block_err_bits == 3'h0);
			end
		end
	end

	// ----------------------------------------
	// Errored block count per set of 48
	// ----------------------------------------
	logic [5:0] set_count_reg;
	logic [5:0] err_count_reg;
	logic [1:0] err_grade_reg;
	wire set_last = (set_count_reg == `ERR_SET_BLOCKS - 6'h01);
	wire [5:0] err_total = err_count_reg + {5'h00, (block_err_bits != 3'h0)};
	wire [1:0] grade_next = (err_total == 6'h00) ? 2'h0
		: (err_total <= `ERR_BIN1_MAX) ? 2'h1
		: (err_total <= `ERR_BIN2_MAX) ? 2'h2 : 2'h3;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			set_count_reg <= 6'h00;
			err_count_reg <= 6'h00;
			err_grade_reg <= 2'h0;
		end
		else if (block_done)
		begin
			set_count_reg <= set_last ? 6'h00 : set_count_reg + 6'h01;
			err_count_reg <= set_last ? 6'h00 : err_total;
			if (set_last)
				err_grade_reg <= grade_next;
		end
	end

	// ----------------------------------------
	// Demodulation phase control
	// ----------------------------------------
	phase_state_t phase_state_reg;
	phase_state_t phase_state_next;
	logic phase_next;

	always_comb
	begin
		phase_state_next = phase_state_reg;
		phase_next = phase_zero_reg;
		case (phase_state_reg)
			PH_AUTO_IDLE:
			begin
				phase_next = cfg_reg.phase_select;
				phase_state_next = PH_AUTO_RUN;
			end
			PH_AUTO_RUN:
			begin
				// Zero degrees with ARI, ninety without
				phase_next = ari_detected;
			end
			default:
			begin
				phase_next = cfg_reg.phase_select;
			end
		endcase
		if (cfg_reg.phase_lock)
			phase_state_next = PH_LOCKED;
		else if (sync_reset || phase_state_reg == PH_LOCKED)
			phase_state_next = PH_AUTO_IDLE;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			phase_state_reg <= PH_AUTO_IDLE;
			phase_zero_reg <= 1'b1;
		end
		else
		begin
			phase_state_reg <= phase_state_next;
			phase_zero_reg <= phase_next;
		end
	end

	// ----------------------------------------
	// Sync pin timing
	// ----------------------------------------
	logic prev_synced_reg;
	logic [15:0] pulse_count_reg;
	wire pulse_running = (pulse_count_reg != 16'h0000);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			prev_synced_reg <= 1'b0;
			pulse_count_reg <= 16'h0000;
		end
		else if (block_start)
		begin
			prev_synced_reg <= synced;
			pulse_count_reg <= 16'(SYNC_PULSE_CYCLES);
		end
		else if (pulse_running)
			pulse_count_reg <= pulse_count_reg - 16'h0001;
	end

	// ----------------------------------------
	// Pin assignment by mode
	// ----------------------------------------
	// Open-drain: a pin only pulls low, so a logical one is a release
	wire traffic_mode = (mode_low == 2'h1);
	wire ari_mode = (mode_low == 2'h2);
	wire grade_mode = (mode_low == 2'h3);
	wire count_mode = (pin_mode == 3'h4);
	wire pin_a_used = traffic_mode || grade_mode || count_mode;
	wire pin_b_used = pin_a_used || ari_mode;
	wire pin_a_active = traffic_mode ? tp_flag : uncorrectable_reg;
	wire pin_b_active = traffic_mode ? ta_flag
		: ari_mode ? ari_detected : !error_free_reg;
	wire pin_a_level = count_mode ? err_grade_reg[1] : (pin_a_active ^ !active_high);
	wire pin_b_level = count_mode ? err_grade_reg[0] : (pin_b_active ^ !active_high);
	wire sync_active = prev_synced_reg && !(grade_mode && pulse_running);
	wire sync_level = sync_active ^ !active_high;
	wire rds_level = rds_detected ^ !active_high;
	wire [BUF_COUNT_BITS-1:0] thresh = (cfg_reg.request_threshold == 2'h0) ? BUF_COUNT_BITS'(`THRESH_1)
		: (cfg_reg.request_threshold == 2'h1) ? BUF_COUNT_BITS'(`THRESH_4)
		: (cfg_reg.request_threshold == 2'h2) ? BUF_COUNT_BITS'(`THRESH_8)
		: BUF_COUNT_BITS'(`THRESH_12);
	wire request_low = (buffered_blocks >= thresh);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			read_request_reg <= '{out: 1'b0, oe_n: 1'b1};
			status_pin_a_reg <= '{out: 1'b0, oe_n: 1'b1};
			status_pin_b_reg <= '{out: 1'b0, oe_n: 1'b1};
			sync_pin_reg <= '{out: 1'b0, oe_n: 1'b1};
			rds_present_pin_reg <= '{out: 1'b0, oe_n: 1'b1};
		end
		else
		begin
			read_request_reg.oe_n <= !request_low;
			status_pin_a_reg.oe_n <= !(pin_a_used && !pin_a_level);
			status_pin_b_reg.oe_n <= !(pin_b_used && !pin_b_level);
			sync_pin_reg.oe_n <= sync_level;
			rds_present_pin_reg.oe_n <= rds_level;
		end
	end

endmodule
`default_nettype wire

// >>> dv/rds_host_model.sv
// Host side of the serial settings bus
`timescale 1ns/10ps
`default_nettype none

module rds_host_model
(
	// Serial pins
	output logic bus_clk,
	output logic bus_ce,
	output logic bus_data
);
	initial
	begin
		bus_clk = 1'h0;
		bus_ce = 1'h0;
		bus_data = 1'h0;
	end

	// Clock runs only on request, so it stands still between frames
	task automatic run(input int n);
		repeat (n)
		begin
			#3 bus_clk = 1'h1;
			#3 bus_clk = 1'h0;
		end
	endtask

	task automatic send(input logic [13:0] w);
		#2.3 bus_ce = 1'h1;
		for (int k = 0; k < 14; k++)
		begin
			bus_data = w[k];
			run(1);
		end
		// Released line shows the opposite level, never a stale copy
		bus_data = ~bus_data;
		#2 bus_ce = 1'h0;
	endtask
endmodule

`default_nettype wire

// >>> dv/rds_cfg_outputs_checker.sv
// Port checks of the decoder control block
`timescale 1ns/10ps
`default_nettype none

module rds_cfg_outputs_checker
	import rds_cfg_pkg::*;
#(
	parameter int BUF_COUNT_BITS = 5
)
(
	// System domain
	input wire logic sys_clk,
	input wire logic rst,
	// Watched ports
	input wire logic block_done,
	input wire logic [2:0] block_err_bits,
	input wire logic [BUF_COUNT_BITS-1:0] buffered_blocks,
	input wire logic [2:0] corr_limit_reg,
	input wire decision_t decision_reg,
	input wire logic soft_enable_reg,
	input wire logic soft_strong_reg,
	input wire logic crystal_select_reg,
	input wire logic phase_zero_reg,
	input wire logic [2:0] err_info_reg,
	input wire logic err_info_valid_reg,
	input wire od_pin_t read_request_reg,
	input wire od_pin_t status_pin_a_reg
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	chk_valid_pulse: assert property (1 |=> err_info_valid_reg == $past(block_done))
		else $error("valid pulse");
	chk_over_limit: assert property (block_done && block_err_bits > corr_limit_reg |=> err_info_reg == 3'h6)
		else $error("over limit code");
	chk_corrected_count: assert property (block_done && block_err_bits <= corr_limit_reg |=> err_info_reg == $past(block_err_bits))
		else $error("corrected count");
	chk_limit_legal: assert property (corr_limit_reg <= 3'h5)
		else $error("illegal limit");
	chk_soft_pair: assert property (soft_enable_reg == (decision_reg != DEC_HARD) && soft_strong_reg == (decision_reg == DEC_SOFT_B))
		else $error("soft flags");
	chk_request_idle: assert property (buffered_blocks == 0 |=> read_request_reg.oe_n)
		else $error("request while empty");
	chk_request_full: assert property (buffered_blocks >= 12 |=> !read_request_reg.oe_n)
		else $error("no request when full");
	chk_reset_values: assert property ($fell(rst) |-> corr_limit_reg == 3'h2 && decision_reg == DEC_SOFT_B && !crystal_select_reg)
		else $error("reset settings");
	chk_phase_start: assert property ($fell(rst) |-> ##[1:3] phase_zero_reg)
		else $error("start phase");
	chk_od_low: assert property (!read_request_reg.out && !status_pin_a_reg.out)
		else $error("pin drives high");
endmodule

bind rds_cfg_outputs rds_cfg_outputs_checker #(.BUF_COUNT_BITS(BUF_COUNT_BITS)) chk_u (.sys_clk, .rst, .block_done,
	.block_err_bits, .buffered_blocks, .corr_limit_reg, .decision_reg, .soft_enable_reg, .soft_strong_reg,
	.crystal_select_reg, .phase_zero_reg, .err_info_reg, .err_info_valid_reg, .read_request_reg, .status_pin_a_reg);

`default_nettype wire

// >>> dv/rds_cfg_outputs_tb_top.sv
// Bench of the decoder control block
`timescale 1ns/10ps
`default_nettype none

module rds_cfg_outputs_tb_top
	import rds_cfg_pkg::*;
;
	logic sys_clk, rst, bus_clk, bus_rst, bus_ce, bus_data, block_start, block_done, sync_reset;
	logic synced, tp_flag, ta_flag, ari_detected, rds_detected;
	logic soft_enable_reg, soft_strong_reg, crystal_select_reg, offset_e_enable_reg, phase_zero_reg, err_info_valid_reg;
	logic [2:0] block_err_bits, corr_limit_reg, err_info_reg;
	logic [4:0] buffered_blocks;
	decision_t decision_reg;
	od_pin_t read_request_reg, status_pin_a_reg, status_pin_b_reg, sync_pin_reg, rds_present_pin_reg;
	settings_t s;
	int n_fail, checked, cyc, i, lim;
	int th[4] = '{1, 4, 8, 12};

	rds_cfg_outputs #(.SYNC_PULSE_CYCLES(20)) dut_u (.sys_clk, .rst, .bus_clk, .bus_rst, .bus_ce, .bus_data,
		.block_start, .block_done, .block_err_bits, .sync_reset, .synced, .tp_flag, .ta_flag, .ari_detected,
		.rds_detected, .buffered_blocks, .corr_limit_reg, .decision_reg, .soft_enable_reg, .soft_strong_reg,
		.crystal_select_reg, .offset_e_enable_reg, .phase_zero_reg, .err_info_reg, .err_info_valid_reg,
		.read_request_reg, .status_pin_a_reg, .status_pin_b_reg, .sync_pin_reg, .rds_present_pin_reg);
	rds_host_model host_u (.bus_clk, .bus_ce, .bus_data);

	initial
	begin
		sys_clk = 1'h0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic pins(input logic a, input logic b);
		check(status_pin_a_reg.oe_n, a);
		check(status_pin_b_reg.oe_n, b);
	endtask

	// Eight cycles cover the two-flop crossing plus capture and decode
	task automatic cfg(input settings_t v);
		host_u.send(v);
		repeat (8) tick();
	endtask

	// Leaves block_done high so blocks can run back to back
	task automatic blk(input logic [2:0] e);
		block_done = 1'h1;
		block_err_bits = e;
		tick();
	endtask

	task automatic report_and_stop();
		if (n_fail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			report_and_stop();
		end
	end

	initial
	begin
		{rst, bus_rst} = 2'h3;
		{block_start, block_done, sync_reset, synced, tp_flag, ta_flag, ari_detected, rds_detected} = 8'h00;
		block_err_bits = 3'h0;
		buffered_blocks = 5'h00;
		fork
			host_u.run(8);
			repeat (16) @(posedge sys_clk);
		join
		#1;
		{rst, bus_rst} = 2'h0;
		check(offset_e_enable_reg, 1'h0);
		check(decision_reg, DEC_SOFT_B);
		// Settings taken from the reset word, not only the reset branch
		repeat (2) tick();
		check(decision_reg, DEC_SOFT_B);
		check(corr_limit_reg, 8'h02);
		buffered_blocks = 5'h01;
		tick();
		check(read_request_reg.oe_n, 1'h0);
		buffered_blocks = 5'h00;
		s = settings_t'(14'h1A12);
		s.decision_mode = 2'h0;
		for (i = 0; i < 8; i++)
		begin
			s.corr_limit = 3'(i);
			cfg(s);
			lim = (i > 5) ? 0 : i;
			check(corr_limit_reg, 8'(lim));
			blk(3'(lim));
			block_done = 1'h0;
			tick();
			check(err_info_reg, 8'(lim));
			pins(1'h1, lim == 0);
			blk(3'(lim + 1));
			block_done = 1'h0;
			tick();
			check(err_info_reg, 8'h06);
			pins(1'h0, 1'h0);
		end
		s.corr_limit = 3'h0;
		for (i = 0; i < 4; i++)
		begin
			s.decision_mode = 2'(i);
			cfg(s);
			check(decision_reg, (i == 3) ? 8'h00 : 8'(i));
			check(soft_enable_reg, i == 1 || i == 2);
			check(soft_strong_reg, i == 2);
		end
		for (i = 0; i < 4; i++)
		begin
			s.request_threshold = 2'(i);
			cfg(s);
			buffered_blocks = 5'(th[i] - 1);
			tick();
			check(read_request_reg.oe_n, 1'h1);
			buffered_blocks = 5'(th[i]);
			tick();
			check(read_request_reg.oe_n, 1'h0);
		end
		buffered_blocks = 5'h00;
		{s.crystal_select, s.standard_select, s.phase_lock, s.phase_select} = 4'hE;
		cfg(s);
		check(crystal_select_reg, 1'h1);
		check(offset_e_enable_reg, 1'h1);
		ari_detected = 1'h1;
		repeat (4) tick();
		check(phase_zero_reg, 1'h0);
		s.phase_select = 1'h1;
		cfg(s);
		check(phase_zero_reg, 1'h1);
		{s.phase_lock, s.phase_select} = 2'h1;
		cfg(s);
		check(phase_zero_reg, 1'h1);
		ari_detected = 1'h0;
		sync_reset = 1'h1;
		tick();
		sync_reset = 1'h0;
		// Restart phase comes from the select bit for one cycle, then ARI rules
		tick();
		check(phase_zero_reg, 1'h1);
		repeat (3) tick();
		check(phase_zero_reg, 1'h0);
		{tp_flag, rds_detected} = 2'h3;
		// Last graded block was uncorrectable, so modes 3 and 7 show both as active
		for (i = 1; i < 8; i += 2)
		begin
			s.pin_mode = 3'(i);
			cfg(s);
			pins(i > 4, i == 1 || i == 7);
			check(rds_present_pin_reg.oe_n, i > 4);
		end
		s.pin_mode = 3'h6;
		cfg(s);
		pins(1'h1, 1'h0);
		s.pin_mode = 3'h0;
		cfg(s);
		pins(1'h1, 1'h1);
		ari_detected = 1'h1;
		s.pin_mode = 3'h2;
		cfg(s);
		pins(1'h1, 1'h0);
		synced = 1'h1;
		repeat (3) tick();
		check(sync_pin_reg.oe_n, 1'h1);
		for (i = 2; i < 4; i++)
		begin
			s.pin_mode = 3'(i);
			cfg(s);
			block_start = 1'h1;
			tick();
			block_start = 1'h0;
			repeat (3) tick();
			check(sync_pin_reg.oe_n, i == 3);
			repeat (25) tick();
			check(sync_pin_reg.oe_n, 1'h0);
		end
		s.pin_mode = 3'h4;
		cfg(s);
		// Any 48 in a row of this pattern hold 21 errored blocks, whatever the set alignment
		for (i = 0; i < 96; i++)
			blk((i % 48 < 21) ? 3'h1 : 3'h0);
		block_done = 1'h0;
		repeat (2) tick();
		pins(1'h1, 1'h0);
		report_and_stop();
	end
endmodule

`default_nettype wire
